/* File: dv/inj_link_monitor.sv */
`timescale 1ns/1ps
module inj_link_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Link
    input wire logic [1:0] valid,
    input wire logic [1:0] ready,
    input wire logic [1:0] last,
    input wire logic [1:0][7:0] data,
    input wire logic [1:0] parseEnable,
    input wire logic precedenceEnable
);
    logic [1:0][4:0] byteCnt_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // ------------------------------------------------------------
    // Byte index in frame, saturates once past the header
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            byteCnt_q <= '0;
        else
            for (int g = 0; g < 2; g++)
                if (valid[g] && ready[g])
                    byteCnt_q[g] <= last[g] ? 5'h0 :
                        (byteCnt_q[g] == 5'h14 ? 5'h14 : byteCnt_q[g] + 5'h1);
    end

    // ------------------------------------------------------------
    // Link checks
    // ------------------------------------------------------------
    for (genvar g = 0; g < 2; g++)
    begin : gLane
        a_valid_held: assert property (valid[g] && !ready[g] |=> valid[g] && $stable(data[g]))
            else $error("offered byte withdrawn");
        a_take_gap: assert property (valid[g] && ready[g] |=> !valid[g])
            else $error("no idle cycle after take");
        // Header bytes never stall, so the header cannot leak into the core stream
        a_header_flow: assert property (valid[g] && ready[g] && parseEnable[g] && !last[g]
            && byteCnt_q[g] <= 5'h13 |=> ready[g])
            else $error("header byte stalled");
        a_payload_held: assert property (valid[g] && ready[g] &&
            (!parseEnable[g] || byteCnt_q[g] == 5'h14) |=> !ready[g])
            else $error("payload byte not held");
        a_ready_back: assert property ($fell(ready[g]) |-> ##[1:40] ready[g])
            else $error("group stuck");
    end
    a_one_group: assert property ($onehot0(valid))
        else $error("both groups offered");
    a_lanes_agree: assert property (|valid |-> data[0] == data[1] && last[0] == last[1])
        else $error("lanes differ");
    a_reset_quiet: assert property ($rose(rstn) |-> valid == 2'b00 && ready == 2'b11
        && parseEnable == 2'b00)
        else $error("link not idle after reset");

    c_parsed_payload: cover property (parseEnable[0] && byteCnt_q[0] == 5'h14 && valid[0]);
    c_group_two: cover property (valid[1] && ready[1]);
    c_precedence: cover property (precedenceEnable && $fell(ready[0]));
endmodule

/* File: dv/test_cpu_frame_injection_header.sv */
`timescale 1ns/1ps
module test_cpu_frame_injection_header;
    typedef struct {logic byp; logic [8:0] cmd; logic [11:0] dst;
        inj_pkg::rewAction_t act; logic [3:0] port; logic [5:0] arg;} row_t;
    logic clk, rstn, ce, hsel, hwrite, hresp, hreadyout, frontRequest, cpuGrant, frontGrant;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, descValid, outValid, outLast, outReady;
    logic [2:0] hsize;
    logic [1:0][7:0] outData;
    inj_pkg::desc_t desc [2];
    inj_pkg::desc_t got;
    int failCount, numChecks, cycles, n, m;
    // Commands carry stray undefined bits; the argument column is what survives cleanup
    row_t rows [8] = '{
        '{1'b1, 9'h000, 12'h801, inj_pkg::ACT_NONE, 4'hb, 6'h00},
        '{1'b1, 9'h1f8, 12'h003, inj_pkg::ACT_SWAP, 4'hb, 6'h01},
        '{1'b1, 9'h151, 12'h00c, inj_pkg::ACT_DSCP, 4'hb, 6'h2a},
        '{1'b1, 9'h1e2, 12'h010, inj_pkg::ACT_PTP_ONE, 4'hb, 6'h04},
        '{1'b1, 9'h03b, 12'h020, inj_pkg::ACT_PTP_TWO, 4'hb, 6'h03},
        '{1'b1, 9'h0f5, 12'h840, inj_pkg::ACT_ORIGIN, 4'hb, 6'h00},
        '{1'b0, 9'h0b0, 12'h000, inj_pkg::ACT_NONE, 4'h5, 6'h00},
        '{1'b0, 9'h000, 12'h000, inj_pkg::ACT_NONE, 4'hb, 6'h00}};

    inj_link_if link ();
    cpu_inject_ctrl i_cpu_inject_ctrl (.clk(clk), .rstn(rstn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link));
    cpu_inject_port i_cpu_inject_port (.clk(clk), .rstn(rstn), .ce(ce), .link(link),
        .descValid(descValid), .desc(desc), .outValid(outValid), .outData(outData),
        .outLast(outLast), .outReady(outReady), .frontRequest(frontRequest),
        .cpuGrant(cpuGrant), .frontGrant(frontGrant));
    inj_link_monitor i_inj_link_monitor (.clk(clk), .rstn(rstn), .valid(link.valid),
        .ready(link.ready), .last(link.last), .data(link.data),
        .parseEnable(link.parseEnable), .precedenceEnable(link.precedenceEnable));

    // ------------------------------------------------------------
    // Bus and reporting tasks
    // ------------------------------------------------------------
    task automatic stopTest();
        if (failCount == 0 && numChecks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] a, input logic [31:0] e);
        numChecks++;
        if (a !== e)
        begin
            failCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
        end
    endtask

    // An idle cycle before each transfer keeps strobes from being driven twice
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic poll(input int b);
        do bus(inj_pkg::REG_STATUS, 1'b0, 32'h0); while (rd[b] !== 1'b0);
    endtask

    task automatic send(input int i);
        logic [159:0] h;
        row_t r;
        int g;
        r = rows[i];
        g = i % 2;
        h = '0;
        h[127] = r.byp;
        h[126] = r.byp && r.cmd == 9'h0;
        h[125:117] = r.cmd;
        h[67:56] = r.dst;
        h[19:17] = 3'(i);
        poll(0);
        for (int k = 0; k < 5; k++)
            bus(8'(8 + 4 * k), 1'b1, h[159 - 32 * k -: 32]);
        bus(inj_pkg::REG_CTRL, 1'b1, {27'h0, 1'b1, 1'(g), 3'b011});
        do @(negedge clk); while (descValid[g] !== 1'b1);
        got = desc[g];
        cmp(got.useAnalyzer, !r.byp);
        cmp(got.rewAction, r.act);
        cmp(got.ingressPort, r.port);
        cmp(got.queuePort, 4'hb);
        cmp(got.smacReplace, h[126]);
        cmp(got.masquerade, !r.byp && r.cmd[4]);
        if (r.byp)
        begin
            cmp({got.destPortSet, got.cpuSelect, got.serviceClass}, {r.dst, r.dst[11], h[19:17]});
            cmp(got.clearSmacBit40, r.act == inj_pkg::ACT_SWAP);
            cmp(got.egressDelay, r.act == inj_pkg::ACT_PTP_ONE && r.cmd[5]);
            if (r.act == inj_pkg::ACT_DSCP)
                cmp(got.rewArg, r.cmd[8:3]);
            if (r.act == inj_pkg::ACT_PTP_TWO)
                cmp(got.rewArg[5:2], 4'h0);
            cmp(got.rewArg, r.arg);
        end
        poll(1);
        bus(inj_pkg::REG_PAYLOAD, 1'b1, {23'h0, 1'b1, 8'(8'h50 + i)});
        do @(negedge clk); while (outValid[g] !== 1'b1);
        cmp({outLast[g], outData[g]}, {1'b1, 8'(8'h50 + i)});
    endtask

    // ------------------------------------------------------------
    // Clock, timeout and main sequence
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failCount++;
            stopTest();
        end
    end

    initial
    begin
        {rstn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {ce, frontRequest, hsize, outReady} = {2'b11, 3'h2, 2'b11};
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 8; i++)
            send(i);
        // Parse off, core stalled, arbitration watched with and without precedence
        for (int p = 0; p < 2; p++)
        begin
            @(posedge clk);
            outReady <= 2'b00;
            bus(inj_pkg::REG_CTRL, 1'b1, {29'h0, 1'(p), 2'b00});
            poll(1);
            bus(inj_pkg::REG_PAYLOAD, 1'b1, 32'h13c);
            do @(negedge clk); while (outValid[0] !== 1'b1);
            repeat (2) @(negedge clk);
            got = desc[0];
            n = 0;
            m = 0;
            repeat (6)
            begin
                @(negedge clk);
                n += int'(cpuGrant);
                m += int'(frontGrant);
            end
            cmp(got.useAnalyzer, 1'b1);
            cmp(got.ingressPort, 4'hb);
            cmp(n, p ? 6 : 3);
            cmp(m, p ? 0 : 3);
            cmp({outValid[0], outData[0]}, 9'h13c);
            @(posedge clk);
            outReady <= 2'b11;
        end
        bus(8'h40, 1'b0, 32'h0);
        cmp(rd, 32'h0);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(negedge clk);
        cmp({link.ready, descValid, outValid}, 6'h30);
        @(posedge clk);
        rstn <= 1'b1;
        bus(inj_pkg::REG_CTRL, 1'b0, 32'h0);
        cmp(rd, 32'h0);
        stopTest();
    end
endmodule

/* File: hdl/cpu_inject_ctrl.sv */
`timescale 1ns/1ps
module cpu_inject_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Injection link
    inj_link_if.cpu link
);
    logic [3:0] ctrl_q;
    logic [inj_pkg::HDR_BITS-1:0] hdr_q;
    logic phase_q;
    logic write_q;
    logic [7:0] addr_q;
    logic hdrActive_q;
    logic [4:0] cnt_q;
    logic pending_q;
    logic [8:0] payload_q;
    logic [1:0] valid_q;
    logic [7:0] data_q;
    logic last_q;
    logic [31:0] rdata_q;
    logic [inj_pkg::HDR_BITS-1:0] wireHdr;
    logic sel;
    logic wrGo;
    logic accepted;

    // ----------------------------------------------------------------
    // Header cleanup
    // ----------------------------------------------------------------
    // undefined command bits zeroed
    function automatic logic [8:0] cleanRewrite(logic [8:0] c);
        logic [8:0] r;
        r = 9'h000;
        if (c[3:0] == inj_pkg::REW_SWAP4)
            r = {5'h00, inj_pkg::REW_SWAP4};
        else if (c[2:0] == inj_pkg::REW_DSCP)
            r = c;
        else if (c[2:0] == inj_pkg::REW_PTP_ONE)
            r = {3'h0, c[inj_pkg::REW_EGR_DELAY_BIT], 2'h0, inj_pkg::REW_PTP_ONE};
        else if (c[2:0] == inj_pkg::REW_PTP_TWO)
            r = {4'h0, c[4:3], inj_pkg::REW_PTP_TWO};
        else if (c[2:0] == inj_pkg::REW_ORIGIN)
            r = {6'h00, inj_pkg::REW_ORIGIN};
        return r;
    endfunction

    always_comb
    begin
        wireHdr = hdr_q;
        if (hdr_q[inj_pkg::BYPASS_BIT])
            wireHdr[inj_pkg::REW_LSB +: inj_pkg::REW_W] =
                cleanRewrite(hdr_q[inj_pkg::REW_LSB +: inj_pkg::REW_W]);
        else if (!hdr_q[inj_pkg::MASQUERADE_BIT])
            wireHdr[inj_pkg::REW_LSB +: inj_pkg::REW_W] = 9'h000;
    end

    assign sel = ctrl_q[inj_pkg::CTRL_SEL_BIT];
    assign wrGo = phase_q && write_q && addr_q == inj_pkg::REG_CTRL
        && hwdata[inj_pkg::CTRL_GO_BIT];
    assign accepted = valid_q[sel] && link.ready[sel];

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    // Zero wait states: read data is prepared in the address phase
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            phase_q <= 1'b0;
            write_q <= 1'b0;
            addr_q <= 8'h00;
            rdata_q <= 32'h0000_0000;
        end
        else if (ce)
        begin
            phase_q <= hsel && htrans[1] && hready;
            if (hsel && htrans[1] && hready)
            begin
                write_q <= hwrite;
                addr_q <= haddr[7:0];
                rdata_q <= 32'h0000_0000;
                if (haddr[7:0] == inj_pkg::REG_CTRL)
                    rdata_q <= {28'h0, ctrl_q};
                else if (haddr[7:0] == inj_pkg::REG_STATUS)
                    rdata_q <= {29'h0, sel, pending_q, hdrActive_q};
                else
                    for (int w = 0; w < inj_pkg::HDR_WORDS; w++)
                        if (haddr[7:0] == inj_pkg::REG_HDR0 + 8'(4 * w))
                            rdata_q <= hdr_q[inj_pkg::HDR_BITS-1-32*w -: 32];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_q <= inj_pkg::CTRL_RESET;
            hdr_q <= '0;
        end
        else if (ce && phase_q && write_q)
        begin
            // Selector and header stay fixed while a header is on the link
            if (addr_q == inj_pkg::REG_CTRL && !hdrActive_q)
                ctrl_q <= hwdata[3:0];
            for (int w = 0; w < inj_pkg::HDR_WORDS; w++)
                if (addr_q == inj_pkg::REG_HDR0 + 8'(4 * w) && !hdrActive_q)
                    hdr_q[inj_pkg::HDR_BITS-1-32*w -: 32] <= hwdata;
        end
    end

    // ----------------------------------------------------------------
    // Link driver
    // ----------------------------------------------------------------
    // header bytes, once started by a go write, go out before any pending payload byte
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            hdrActive_q <= 1'b0;
            cnt_q <= inj_pkg::CNT_RESET;
            pending_q <= 1'b0;
            payload_q <= 9'h000;
            valid_q <= 2'b00;
            data_q <= 8'h00;
            last_q <= 1'b0;
        end
        else if (ce)
        begin
            if (wrGo && !hdrActive_q)
            begin
                hdrActive_q <= 1'b1;
                cnt_q <= inj_pkg::CNT_RESET;
            end
            // A second byte written while one waits is dropped
            if (phase_q && write_q && addr_q == inj_pkg::REG_PAYLOAD && !pending_q)
            begin
                pending_q <= 1'b1;
                payload_q <= hwdata[8:0];
            end
            if (accepted)
            begin
                valid_q <= 2'b00;
                if (hdrActive_q && cnt_q == inj_pkg::HDR_LAST_IDX)
                    hdrActive_q <= 1'b0;
                if (hdrActive_q)
                    cnt_q <= cnt_q + 5'h01;
            end
            else if (valid_q == 2'b00)
            begin
                if (hdrActive_q)
                begin
                    valid_q[sel] <= 1'b1;
                    data_q <= wireHdr[inj_pkg::HDR_BITS-1-8*cnt_q -: 8];
                    last_q <= 1'b0;
                end
                else if (pending_q)
                begin
                    valid_q[sel] <= 1'b1;
                    data_q <= payload_q[7:0];
                    last_q <= payload_q[inj_pkg::PAYLOAD_LAST_BIT];
                    pending_q <= 1'b0;
                end
            end
        end
    end

    assign link.valid = valid_q;
    assign link.data = {data_q, data_q};
    assign link.last = {last_q, last_q};
    assign link.parseEnable = ctrl_q[1:0];
    assign link.precedenceEnable = ctrl_q[inj_pkg::CTRL_PREC_BIT];
    assign hrdata = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
endmodule

/* File: hdl/cpu_inject_port.sv */
`timescale 1ns/1ps
module cpu_inject_port (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Injection link
    inj_link_if.device link,
    // Frame descriptors toward the core
    output logic [1:0] descValid,
    output inj_pkg::desc_t desc [2],
    // Frame bytes toward the core
    output logic [1:0] outValid,
    output logic [1:0][7:0] outData,
    output logic [1:0] outLast,
    input wire logic [1:0] outReady,
    // Egress queue arbitration
    input wire logic frontRequest,
    output logic cpuGrant,
    output logic frontGrant
);
    logic [1:0] ready_q;
    logic [1:0] atStart_q;
    logic [1:0] inHdr_q;
    logic [4:0] cnt_q [2];
    logic [inj_pkg::HDR_BITS-9:0] hdr_q [2];
    logic [1:0] descValid_q;
    inj_pkg::desc_t desc_q [2];
    logic [1:0] outValid_q;
    logic [1:0][7:0] outData_q;
    logic [1:0] outLast_q;
    logic cpuGrant_q;
    logic frontGrant_q;
    logic lastWinner_q;

    // ----------------------------------------------------------------
    // Header decode
    // ----------------------------------------------------------------
    function automatic inj_pkg::rewAction_t decodeRewrite(logic [8:0] c);
        inj_pkg::rewAction_t a;
        a = inj_pkg::ACT_NONE;
        if (c[3:0] == inj_pkg::REW_NOP4)
            a = inj_pkg::ACT_NONE;
        else if (c[3:0] == inj_pkg::REW_SWAP4)
            a = inj_pkg::ACT_SWAP;
        else if (c[2:0] == inj_pkg::REW_DSCP)
            a = inj_pkg::ACT_DSCP;
        else if (c[2:0] == inj_pkg::REW_PTP_ONE)
            a = inj_pkg::ACT_PTP_ONE;
        else if (c[2:0] == inj_pkg::REW_PTP_TWO)
            a = inj_pkg::ACT_PTP_TWO;
        else if (c[2:0] == inj_pkg::REW_ORIGIN)
            a = inj_pkg::ACT_ORIGIN;
        return a;
    endfunction

    function automatic inj_pkg::desc_t buildDesc(logic [inj_pkg::HDR_BITS-1:0] h,
                                                 logic parsed);
        inj_pkg::desc_t d;
        logic [8:0] cmd;
        d = '0;
        cmd = h[inj_pkg::REW_LSB +: inj_pkg::REW_W];
        d.rewAction = inj_pkg::ACT_NONE;
        d.queuePort = inj_pkg::CPU_PORT_PRIMARY;
        d.ingressPort = inj_pkg::CPU_PORT_PRIMARY;
        d.useAnalyzer = 1'b1;
        if (parsed)
        begin
            d.smacReplace = h[inj_pkg::SMAC_BIT];
            if (h[inj_pkg::BYPASS_BIT])
            begin
                d.useAnalyzer = 1'b0;
                d.destPortSet = h[inj_pkg::PORTSET_LSB +: inj_pkg::PORTSET_W];
                d.cpuSelect = h[inj_pkg::PORTSET_LSB + inj_pkg::CPU_PORTSET_BIT];
                d.serviceClass = h[inj_pkg::QOS_LSB +: inj_pkg::QOS_W];
                d.tagPopCount = h[inj_pkg::POP_LSB +: inj_pkg::POP_W];
                d.tagType = h[inj_pkg::TAGTYPE_BIT];
                d.pcp = h[inj_pkg::PCP_LSB +: inj_pkg::PCP_W];
                d.dei = h[inj_pkg::DEI_BIT];
                d.vid = h[inj_pkg::VID_LSB +: inj_pkg::VID_W];
                d.rewAction = decodeRewrite(cmd);
                d.rewArg = cmd[8:3];
                d.egressDelay = d.rewAction == inj_pkg::ACT_PTP_ONE
                    && cmd[inj_pkg::REW_EGR_DELAY_BIT];
                d.clearSmacBit40 = d.rewAction == inj_pkg::ACT_SWAP;
            end
            else if (h[inj_pkg::MASQUERADE_BIT])
            begin
                d.masquerade = 1'b1;
                d.ingressPort = h[inj_pkg::MASQUERADE_PORT_LSB +: inj_pkg::MASQUERADE_PORT_W];
            end
        end
        return d;
    endfunction

    // ----------------------------------------------------------------
    // Injection groups
    // ----------------------------------------------------------------
    // one independent path per group
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ready_q <= 2'b11;
            atStart_q <= 2'b11;
            inHdr_q <= 2'b00;
            descValid_q <= 2'b00;
            outValid_q <= 2'b00;
            outData_q <= '0;
            outLast_q <= 2'b00;
            for (int g = 0; g < inj_pkg::GROUPS; g++)
            begin
                cnt_q[g] <= inj_pkg::CNT_RESET;
                hdr_q[g] <= '0;
                desc_q[g] <= '0;
            end
        end
        else if (ce)
        begin
            for (int g = 0; g < inj_pkg::GROUPS; g++)
            begin
                descValid_q[g] <= 1'b0;
                if (outValid_q[g] && outReady[g])
                begin
                    outValid_q[g] <= 1'b0;
                    ready_q[g] <= 1'b1;
                end
                if (link.valid[g] && ready_q[g])
                begin
                    atStart_q[g] <= link.last[g];
                    if ((atStart_q[g] && link.parseEnable[g]) || inHdr_q[g])
                    begin
                        // header bytes are not frame data
                        hdr_q[g] <= {hdr_q[g][inj_pkg::HDR_BITS-17:0], link.data[g]};
                        cnt_q[g] <= cnt_q[g] + 5'h01;
                        inHdr_q[g] <= cnt_q[g] != inj_pkg::HDR_LAST_IDX
                            && !link.last[g];
                        if (cnt_q[g] == inj_pkg::HDR_LAST_IDX)
                        begin
                            desc_q[g] <= buildDesc({hdr_q[g], link.data[g]}, 1'b1);
                            descValid_q[g] <= 1'b1;
                        end
                    end
                    else
                    begin
                        // Half rate: one byte held until the core takes it
                        outValid_q[g] <= 1'b1;
                        outData_q[g] <= link.data[g];
                        outLast_q[g] <= link.last[g];
                        ready_q[g] <= 1'b0;
                        if (atStart_q[g])
                        begin
                            desc_q[g] <= buildDesc('0, 1'b0);
                            descValid_q[g] <= 1'b1;
                        end
                    end
                    if (link.last[g])
                        cnt_q[g] <= inj_pkg::CNT_RESET;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Egress queue arbitration
    // ----------------------------------------------------------------
    // CPU precedence over front ports
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cpuGrant_q <= 1'b0;
            frontGrant_q <= 1'b0;
            lastWinner_q <= 1'b0;
        end
        else if (ce)
        begin
            if (|outValid_q && (link.precedenceEnable || !frontRequest || lastWinner_q == 1'b0))
            begin
                cpuGrant_q <= 1'b1;
                frontGrant_q <= 1'b0;
                lastWinner_q <= 1'b1;
            end
            else
            begin
                // Without precedence the two sides alternate
                cpuGrant_q <= 1'b0;
                frontGrant_q <= frontRequest;
                lastWinner_q <= 1'b0;
            end
        end
    end

    assign link.ready = ready_q;
    assign descValid = descValid_q;
    assign desc = desc_q;
    assign outValid = outValid_q;
    assign outData = outData_q;
    assign outLast = outLast_q;
    assign cpuGrant = cpuGrant_q;
    assign frontGrant = frontGrant_q;
endmodule

/* File: include/inj_link_if.sv */
`timescale 1ns/1ps
interface inj_link_if;
    logic [1:0] valid;
    logic [1:0] ready;
    logic [1:0] last;
    logic [1:0][7:0] data;
    logic [1:0] parseEnable;
    logic precedenceEnable;

    modport device (
        input valid,
        input last,
        input data,
        input parseEnable,
        input precedenceEnable,
        output ready
    );

    modport cpu (
        output valid,
        output last,
        output data,
        output parseEnable,
        output precedenceEnable,
        input ready
    );
endinterface

/* File: include/inj_pkg.sv */
package inj_pkg;

    // ----------------------------------------------------------------
    // Frame and header geometry
    // ----------------------------------------------------------------
    localparam int GROUPS = 2;
    localparam int HDR_BYTES = 20;
    localparam int HDR_BITS = 160;
    localparam logic [4:0] HDR_LAST_IDX = 5'h13;
    localparam logic [4:0] CNT_RESET = 5'h00;

    // ----------------------------------------------------------------
    // Header field positions
    // ----------------------------------------------------------------
    localparam int BYPASS_BIT = 127;
    localparam int SMAC_BIT = 126;
    localparam int REW_LSB = 117;
    localparam int REW_W = 9;
    localparam int MASQUERADE_BIT = 121;
    localparam int MASQUERADE_PORT_LSB = 122;
    localparam int MASQUERADE_PORT_W = 4;
    localparam int PORTSET_LSB = 56;
    localparam int PORTSET_W = 12;
    localparam int CPU_PORTSET_BIT = 11;
    localparam int POP_LSB = 28;
    localparam int POP_W = 2;
    localparam int QOS_LSB = 17;
    localparam int QOS_W = 3;
    localparam int TAGTYPE_BIT = 16;
    localparam int PCP_LSB = 13;
    localparam int PCP_W = 3;
    localparam int DEI_BIT = 12;
    localparam int VID_LSB = 0;
    localparam int VID_W = 12;

    // ----------------------------------------------------------------
    // Ports and rewrite command codes
    // ----------------------------------------------------------------
    localparam logic [3:0] CPU_PORT_PRIMARY = 4'hb;
    localparam logic [3:0] CPU_PORT_SECOND = 4'hc;
    localparam logic [3:0] REW_NOP4 = 4'h0;
    localparam logic [3:0] REW_SWAP4 = 4'h8;
    localparam logic [2:0] REW_DSCP = 3'h1;
    localparam logic [2:0] REW_PTP_ONE = 3'h2;
    localparam logic [2:0] REW_PTP_TWO = 3'h3;
    localparam logic [2:0] REW_ORIGIN = 3'h5;
    localparam int REW_EGR_DELAY_BIT = 5;

    typedef enum logic [2:0] {
        ACT_NONE,
        ACT_SWAP,
        ACT_DSCP,
        ACT_PTP_ONE,
        ACT_PTP_TWO,
        ACT_ORIGIN
    } rewAction_t;

    typedef struct packed {
        logic useAnalyzer;
        logic [3:0] queuePort;
        logic [3:0] ingressPort;
        logic masquerade;
        logic smacReplace;
        logic [11:0] destPortSet;
        logic cpuSelect;
        logic [2:0] serviceClass;
        logic [1:0] tagPopCount;
        logic tagType;
        logic [2:0] pcp;
        logic dei;
        logic [11:0] vid;
        rewAction_t rewAction;
        logic [5:0] rewArg;
        logic egressDelay;
        logic clearSmacBit40;
    } desc_t;

    // ----------------------------------------------------------------
    // Controller register map (byte offsets) and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_HDR0 = 8'h08;
    localparam logic [7:0] REG_PAYLOAD = 8'h1c;
    localparam int HDR_WORDS = 5;
    localparam int CTRL_GO_BIT = 4;
    localparam int CTRL_SEL_BIT = 3;
    localparam int CTRL_PREC_BIT = 2;
    localparam int PAYLOAD_LAST_BIT = 8;
    localparam logic [3:0] CTRL_RESET = 4'h0;

endpackage
